/* File: tvpll_map.svh */
// Register offsets, field positions, reset values and fixed constants of the TV PLL register bank
`ifndef TVPLL_MAP_SVH
`define TVPLL_MAP_SVH
`define OFS_CONTRAST_GAIN 8'h08
`define OFS_TV_PLL_CONTROL 8'h09
`define OFS_REF_DIVIDER_LOW 8'h0A
`define OFS_VCO_DIVIDER_LOW 8'h0B
`define OFS_STEP_BYTE3 8'h0C
`define OFS_STEP_BYTE2 8'h0D
`define OFS_STEP_BYTE1 8'h0E
`define OFS_STEP_BYTE0 8'h0F
`define RST_CONTRAST_GAIN 3'h3
`define RST_TV_PLL_CONTROL 8'h80
`define RST_REF_DIVIDER_LOW 8'h3F
`define RST_VCO_DIVIDER_LOW 8'h7E
`define RST_STEP 32'h00000000
`define BIT_LOOP_CAP 0
`define BIT_CP_TRIM 1
`define BIT_REF_MSB 2
`define BIT_VCO_B8 3
`define BIT_VCO_B9 4
`define BIT_LATCH_BIAS 5
`define BIT_SENSE_LO 6
`define BIT_SENSE_HI 7
`define CONTRAST_UNITY 3'h1
`define SLAVE_DIV_ONE 10'h001
`define REF_FREQ_HZ 14318180
`endif

/* File: tvpll_pkg.sv */
// Types shared by the TV PLL register bank
package tvpll_pkg;
   typedef enum logic [1:0] {CON_REDUCE, CON_UNITY, CON_BOOST} contrast_mode_e;
   typedef struct packed {
      logic [1:0] sense_ref;
      logic latch_bias;
      logic charge_pump_trim;
      logic loop_cap_select;
   } pll_analog_s;
   typedef struct packed {
      logic [8:0] ref_divider;
      logic [9:0] vco_divider;
   } pll_div_s;
endpackage

/* File: tv_pll_subcarrier_regs.sv */
// TV encoder contrast, TV PLL and sub-carrier increment register bank
//
// Function
// - Contrast: zero reduces, one unity, more boosts
// - Control bit zero picks loop capacitor
// - Control bits four-two hold divider MSBs
// - Control bit five sets latch bias
// - Control bits seven-six set sense reference
// - Master: nine-bit reference divider used
// - Slave: pixel clock reference, rate select
// - Master: ten-bit VCO divider used
// - Slave: VCO divider forced to one
// - Pixel clock = ref*(N+2)/(M+2)
// - Auto select zero uses programmed step
// - Step split MSB-first across four bytes
// - Auto select one uses calculated step
// - Master: fixed reference, programmed dividers
// - Slave: input clock reference, dividers one
`timescale 1ns/1ps
`include "tvpll_map.svh"
module tv_pll_subcarrier_regs
   import tvpll_pkg::*;
#(
   parameter int ROM_ADDR_W = 10
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Serial port register access
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Mode inputs from neighbouring registers
   input wire logic i_master_mode,
   input wire logic i_auto_increment_select,
   input wire logic [31:0] i_calculated_step,
   input wire logic i_pixel_tick,
   // Encoder and PLL controls
   output logic [2:0] o_contrast_gain,
   output contrast_mode_e o_contrast_mode,
   output pll_analog_s o_pll_analog,
   output pll_div_s o_pll_div,
   output logic o_ref_is_fixed,
   output logic [31:0] o_step_sel,
   output logic [ROM_ADDR_W-1:0] o_rom_addr
);

   // ************************************************************
   // Register storage
   // ************************************************************
   logic [2:0] contrast_gain_r;
   logic [7:0] tv_pll_control_r;
   logic [7:0] ref_divider_low_r;
   logic [7:0] vco_divider_low_r;
   logic [31:0] step_r;
   logic [31:0] phase_r;
   logic [31:0] phase_nxt;
   logic [7:0] rdata_nxt;

   // Write decode, one strobe per byte register
   // Full eight-bit decode: offsets outside the bank never alias onto it
   wire wr_con = i_reg_wr && (i_reg_addr == `OFS_CONTRAST_GAIN);
   wire wr_tpc = i_reg_wr && (i_reg_addr == `OFS_TV_PLL_CONTROL);
   wire wr_refl = i_reg_wr && (i_reg_addr == `OFS_REF_DIVIDER_LOW);
   wire wr_vcol = i_reg_wr && (i_reg_addr == `OFS_VCO_DIVIDER_LOW);
   wire [3:0] wr_step;

   // ************************************************************
   // Register writes
   // ************************************************************
   // independent byte writes
   // Contrast keeps bits 2:0 only; upper write bits are dropped
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         contrast_gain_r <= `RST_CONTRAST_GAIN;
         tv_pll_control_r <= `RST_TV_PLL_CONTROL;
         ref_divider_low_r <= `RST_REF_DIVIDER_LOW;
         vco_divider_low_r <= `RST_VCO_DIVIDER_LOW;
      end
      else
      begin
         if (wr_con)
            contrast_gain_r <= i_reg_wdata[2:0];
         if (wr_tpc)
            tv_pll_control_r <= i_reg_wdata;
         if (wr_refl)
            ref_divider_low_r <= i_reg_wdata;
         if (wr_vcol)
            vco_divider_low_r <= i_reg_wdata;
      end
   end

   // No atomic update: a step written byte by byte is mixed in between
   // byte three at lowest offset
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_step
         assign wr_step[g] = i_reg_wr && (i_reg_addr == (`OFS_STEP_BYTE0 - 8'(g)));
         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst)
               step_r[8*g +: 8] <= 8'(`RST_STEP >> (8*g));
            else if (wr_step[g])
               step_r[8*g +: 8] <= i_reg_wdata;
         end
      end
   endgenerate

   // ************************************************************
   // Derived controls
   // ************************************************************
   // assemble full divider fields
   wire [8:0] ref_div_full = {tv_pll_control_r[`BIT_REF_MSB], ref_divider_low_r};
   wire [9:0] vco_div_full = {tv_pll_control_r[`BIT_VCO_B9], tv_pll_control_r[`BIT_VCO_B8],
                              vco_divider_low_r};
   // slave forces ones
   // Programmed divider bits stay readable in slave mode; only the outputs
   // are forced, so a return to master mode restores them
   wire [8:0] ref_div_eff = i_master_mode ? ref_div_full : 9'(`SLAVE_DIV_ONE);
   wire [9:0] vco_div_eff = i_master_mode ? vco_div_full : `SLAVE_DIV_ONE;
   wire contrast_mode_e con_nxt = (contrast_gain_r == 3'h0) ? CON_REDUCE :
      (contrast_gain_r == `CONTRAST_UNITY) ? CON_UNITY : CON_BOOST;
   wire [31:0] step_sel_nxt = i_auto_increment_select ? i_calculated_step : step_r;

   // phase accumulator advances per pixel
   // Carry out of bit 31 is dropped: the phase wraps once per sub-carrier cycle
   always_comb
   begin
      phase_nxt = phase_r;
      if (i_pixel_tick)
         phase_nxt = 32'(phase_r + o_step_sel);
   end

   // Read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_nxt = 8'h00;
      unique case (i_reg_addr)
         `OFS_CONTRAST_GAIN: rdata_nxt = {5'h00, contrast_gain_r};
         `OFS_TV_PLL_CONTROL: rdata_nxt = tv_pll_control_r;
         `OFS_REF_DIVIDER_LOW: rdata_nxt = ref_divider_low_r;
         `OFS_VCO_DIVIDER_LOW: rdata_nxt = vco_divider_low_r;
         `OFS_STEP_BYTE3: rdata_nxt = step_r[31:24];
         `OFS_STEP_BYTE2: rdata_nxt = step_r[23:16];
         `OFS_STEP_BYTE1: rdata_nxt = step_r[15:8];
         `OFS_STEP_BYTE0: rdata_nxt = step_r[7:0];
         default: rdata_nxt = 8'h00;
      endcase
   end

   // ************************************************************
   // Registered outputs
   // ************************************************************
   // Outputs lag the registers by one cycle so all come from flops
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_reg_rdata <= 8'h00;
         o_contrast_gain <= `RST_CONTRAST_GAIN;
         o_contrast_mode <= CON_BOOST;
         o_pll_analog <= '0;
         o_pll_div <= '0;
         o_ref_is_fixed <= 1'b0;
         o_step_sel <= 32'h00000000;
         phase_r <= 32'h00000000;
         o_rom_addr <= '0;
      end
      else
      begin
         // Read data moves only on a read strobe, so it stands for software
         if (i_reg_rd)
            o_reg_rdata <= rdata_nxt;
         o_contrast_gain <= contrast_gain_r;
         o_contrast_mode <= con_nxt;
         o_pll_analog <= '{sense_ref: tv_pll_control_r[`BIT_SENSE_HI:`BIT_SENSE_LO],
                           latch_bias: tv_pll_control_r[`BIT_LATCH_BIAS],
                           charge_pump_trim: tv_pll_control_r[`BIT_CP_TRIM],
                           loop_cap_select: tv_pll_control_r[`BIT_LOOP_CAP]};
         o_pll_div <= '{ref_divider: ref_div_eff, vco_divider: vco_div_eff};
         // slave takes pixel clock as reference
         o_ref_is_fixed <= i_master_mode;
         o_step_sel <= step_sel_nxt;
         phase_r <= phase_nxt;
         o_rom_addr <= phase_nxt[31 -: ROM_ADDR_W];
      end
   end

   // ************************************************************
   // Checks: clock control and PLL fields
   // ************************************************************
   // Output checks skip the first edge after reset: the output flops then
   // still hold reset values, not copies of the registers
   // slave divider forcing
   slave_div_one_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst) && !$past(i_master_mode)
      |-> o_pll_div.vco_divider == 10'h001 && o_pll_div.ref_divider == 9'h001)
      else $error("slave dividers not forced to one");

   master_div_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst) && $past(i_master_mode)
      |-> o_pll_div.vco_divider[9:8] == $past(tv_pll_control_r[4:3])
      && o_pll_div.ref_divider[8] == $past(tv_pll_control_r[2]))
      else $error("divider msb mismatch");

   ref_div_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst) && $past(i_master_mode)
      |-> o_pll_div.ref_divider[7:0] == $past(ref_divider_low_r))
      else $error("reference divider low byte lost");

   vco_div_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst) && $past(i_master_mode)
      |-> o_pll_div.vco_divider[7:0] == $past(vco_divider_low_r))
      else $error("VCO divider low byte lost");

   ref_source_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst) |-> o_ref_is_fixed == $past(i_master_mode))
      else $error("reference source does not follow clock mode");

   loop_cap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst)
      |-> o_pll_analog.loop_cap_select == $past(tv_pll_control_r[`BIT_LOOP_CAP]))
      else $error("loop capacitor select mismatch");

   latch_bias_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst)
      |-> o_pll_analog.latch_bias == $past(tv_pll_control_r[`BIT_LATCH_BIAS]))
      else $error("latch bias mismatch");

   sense_ref_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst)
      |-> o_pll_analog.sense_ref == $past(tv_pll_control_r[`BIT_SENSE_HI:`BIT_SENSE_LO]))
      else $error("sense reference mismatch");

   // ************************************************************
   // Checks: contrast
   // ************************************************************
   // contrast class
   contrast_class_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_contrast_gain == 3'h1) == (o_contrast_mode == CON_UNITY))
      else $error("contrast class mismatch");

   contrast_reduce_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_contrast_gain == 3'h0) == (o_contrast_mode == CON_REDUCE))
      else $error("contrast reduce class mismatch");

   contrast_copy_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst) |-> o_contrast_gain == $past(contrast_gain_r))
      else $error("contrast output does not follow register");

   // ************************************************************
   // Checks: register access
   // ************************************************************
   // byte order
   step_order_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_reg_wr && i_reg_addr == `OFS_STEP_BYTE3
      |=> step_r[31:24] == $past(i_reg_wdata))
      else $error("top step byte not at lowest offset");

   step_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_reg_wr && i_reg_addr == `OFS_STEP_BYTE0
      |=> step_r[7:0] == $past(i_reg_wdata))
      else $error("low step byte not at highest offset");

   readback_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_reg_wr && i_reg_addr == 8'h0A ##1 i_reg_rd && i_reg_addr == 8'h0A && !i_reg_wr
      |=> o_reg_rdata == $past(i_reg_wdata, 2))
      else $error("readback mismatch");

   control_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_reg_wr && i_reg_addr == `OFS_TV_PLL_CONTROL
      |=> tv_pll_control_r == $past(i_reg_wdata))
      else $error("control write lost");

   contrast_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_reg_wr && i_reg_addr == `OFS_CONTRAST_GAIN
      |=> contrast_gain_r == $past(i_reg_wdata[2:0]))
      else $error("contrast write mismatch");

   unmapped_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_reg_rd && (i_reg_addr < `OFS_CONTRAST_GAIN || i_reg_addr > `OFS_STEP_BYTE0)
      |=> o_reg_rdata == 8'h00)
      else $error("unmapped offset read nonzero");

   rdata_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data changed without a read");

   // ************************************************************
   // Checks: sub-carrier step
   // ************************************************************
   // Software changes the step byte by byte, so a mixed value is legal here
   // step source
   step_source_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst) && !$past(i_auto_increment_select)
      |-> o_step_sel == $past(step_r))
      else $error("programmed step not selected");

   auto_source_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst) && $past(i_auto_increment_select)
      |-> o_step_sel == $past(i_calculated_step))
      else $error("calculated step not selected");

   phase_step_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_pixel_tick |=> phase_r == $past(phase_r) + $past(o_step_sel))
      else $error("phase did not advance");

   phase_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !i_pixel_tick |=> phase_r == $past(phase_r))
      else $error("phase moved without a pixel tick");
endmodule

/* File: tb_tv_pll_subcarrier_regs.sv */
// Self-checking testbench for the TV PLL and sub-carrier register bank
`timescale 1ns/1ps
`include "tvpll_map.svh"
module tb_tv_pll_subcarrier_regs
   import tvpll_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [7:0] i_reg_addr = 8'h00;
   logic [7:0] i_reg_wdata = 8'h00;
   logic i_master_mode = 1'b1;
   logic i_auto_increment_select = 1'b0;
   logic [31:0] i_calculated_step = 32'hA5A51234;
   logic i_pixel_tick = 1'b0;
   logic [7:0] o_reg_rdata;
   logic [2:0] o_contrast_gain;
   contrast_mode_e o_contrast_mode;
   pll_analog_s o_pll_analog;
   pll_div_s o_pll_div;
   logic o_ref_is_fixed;
   logic [31:0] o_step_sel;
   logic [9:0] o_rom_addr;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [7:0] rst_tab [8] = '{8'h03, 8'h80, 8'h3F, 8'h7E, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [31:0] acc = 32'h00000000;

   tv_pll_subcarrier_regs #(.ROM_ADDR_W(10)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_master_mode(i_master_mode),
      .i_auto_increment_select(i_auto_increment_select),
      .i_calculated_step(i_calculated_step), .i_pixel_tick(i_pixel_tick),
      .o_contrast_gain(o_contrast_gain), .o_contrast_mode(o_contrast_mode),
      .o_pll_analog(o_pll_analog), .o_pll_div(o_pll_div), .o_ref_is_fixed(o_ref_is_fixed),
      .o_step_sel(o_step_sel), .o_rom_addr(o_rom_addr));

   // 10 MHz clock
   initial
   begin
      forever #50 i_clk = ~i_clk;
   end

   // Cycle ceiling: the whole run needs well under a thousand cycles
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Each access raises its own strobe and drops the other; settle drops both,
   // so no strobe is lowered and raised again in one time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_rd = 1'b0;
      i_reg_wr = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(posedge i_clk) #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b1;
      i_reg_addr = a;
      @(posedge i_clk) #1;
      check(32'(o_reg_rdata), 32'(exp));
   endtask

   // Derived outputs lag a register write by two edges
   task automatic settle();
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge i_clk);
      #1;
      i_sys_rst = 1'b0;
      settle();
      // ************************************************
      // Reset values and reset-state outputs
      // ************************************************
      for (int i = 0; i < 8; i++)
         rd(8'(`OFS_CONTRAST_GAIN + i), rst_tab[i]);
      check(32'(o_pll_div), {13'h0, 9'h03F, 10'h07E});
      check(32'(o_pll_analog), 32'h10);
      $display("test reset_values done");
      // ************************************************
      // Contrast codes, upper bits dropped
      // ************************************************
      for (int v = 0; v < 8; v++)
      begin
         wr(`OFS_CONTRAST_GAIN, 8'hF8 | 8'(v));
         rd(`OFS_CONTRAST_GAIN, 8'(v));
         settle();
         check(32'(o_contrast_mode), (v == 0) ? 32'd0 : ((v == 1) ? 32'd1 : 32'd2));
         check(32'(o_contrast_gain), 32'(v));
      end
      $display("test contrast done");
      // ************************************************
      // Control bits and divider assembly
      // ************************************************
      wr(`OFS_TV_PLL_CONTROL, 8'h81);
      wr(`OFS_REF_DIVIDER_LOW, 8'h0D);
      rd(`OFS_REF_DIVIDER_LOW, 8'h0D);
      wr(`OFS_VCO_DIVIDER_LOW, 8'h14);
      settle();
      check(32'(o_pll_div), {13'h0, 9'd13, 10'd20});
      check(32'(o_pll_analog), 32'h11);
      wr(`OFS_TV_PLL_CONTROL, 8'h7D);
      wr(`OFS_REF_DIVIDER_LOW, 8'hFF);
      wr(`OFS_VCO_DIVIDER_LOW, 8'hFF);
      rd(`OFS_TV_PLL_CONTROL, 8'h7D);
      settle();
      check(32'(o_pll_div), {13'h0, 9'h1FF, 10'h3FF});
      check(32'(o_pll_analog), 32'h0D);
      wr(`OFS_TV_PLL_CONTROL, 8'hA0);
      settle();
      check(32'(o_pll_div), {13'h0, 9'h0FF, 10'h0FF});
      check(32'(o_pll_analog), 32'h14);
      $display("test pll_control done");
      // ************************************************
      // Slave mode forces both dividers to one
      // ************************************************
      i_master_mode = 1'b0;
      settle();
      check(32'(o_pll_div), {13'h0, 9'h001, 10'h001});
      check(32'(o_ref_is_fixed), 32'h0);
      i_master_mode = 1'b1;
      settle();
      check(32'(o_ref_is_fixed), 32'h1);
      check(32'(o_pll_div), {13'h0, 9'h0FF, 10'h0FF});
      $display("test clock_mode done");
      // ************************************************
      // Step bytes, selection and accumulation
      // ************************************************
      wr(`OFS_STEP_BYTE3, 8'h2D);
      wr(`OFS_STEP_BYTE2, 8'h80);
      wr(`OFS_STEP_BYTE1, 8'h0C);
      wr(`OFS_STEP_BYTE0, 8'h7C);
      settle();
      check(o_step_sel, 32'h2D800C7C);
      wr(`OFS_STEP_BYTE0, 8'h00);
      rd(`OFS_STEP_BYTE1, 8'h0C);
      settle();
      check(o_step_sel, 32'h2D800C00);
      i_auto_increment_select = 1'b1;
      settle();
      check(o_step_sel, 32'hA5A51234);
      i_auto_increment_select = 1'b0;
      wr(`OFS_STEP_BYTE3, 8'h2D);
      wr(`OFS_STEP_BYTE2, 8'h80);
      wr(`OFS_STEP_BYTE1, 8'h00);
      wr(`OFS_STEP_BYTE0, 8'h00);
      settle();
      check(o_step_sel, 32'd763363328);
      // Tick held high for three edges, so the accumulator steps three times
      i_pixel_tick = 1'b1;
      for (int t = 0; t < 3; t++)
      begin
         @(posedge i_clk) #1;
         acc = acc + 32'd763363328;
         check(32'(o_rom_addr), 32'(acc[31:22]));
      end
      i_pixel_tick = 1'b0;
      $display("test subcarrier done");
      // ************************************************
      // Unmapped offset is ignored and reads zero
      // ************************************************
      wr(8'h10, 8'hAA);
      rd(8'h10, 8'h00);
      rd(`OFS_STEP_BYTE3, 8'h2D);
      $display("test unmapped done");
      // ************************************************
      // Reset in mid-run restores the bank
      // ************************************************
      settle();
      i_sys_rst = 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      i_sys_rst = 1'b0;
      settle();
      rd(`OFS_STEP_BYTE3, 8'h00);
      rd(`OFS_TV_PLL_CONTROL, 8'h80);
      check(32'(o_contrast_gain), 32'h3);
      check(32'(o_pll_div), {13'h0, 9'h03F, 10'h07E});
      $display("test mid_reset done");
      summarize();
   end
endmodule
